// ---- common/hbpw_defines.vh ----
// hbpw_defines.vh: constants of the four-channel bridge controller
`ifndef HBPW_DEFINES_VH
`define HBPW_DEFINES_VH
`define HB_CLK_NS        100
`define HB_US_NS         1000
`define HB_US_CYC        (`HB_US_NS / `HB_CLK_NS)
`define HB_STEP_US       50
`define HB_STEP_ROUND    17'h00031
`define HB_STEP_DIV      17'h00032
`define HB_US_LAST       4'h9
`define HB_ST_LAST       6'h31
`define HB_CHOP_MIN_US   16'h0014
`define HB_PROF_MIN_TK   11'h028
`define HB_INRUSH_MAX_MA 16'h2710
`define HB_HOLD_MAX_MA   16'h1770
`define HB_HI_CUR_MS     2000
`define HB_HI_CUR_TICKS  (`HB_HI_CUR_MS * 1000 / `HB_STEP_US)
`define HB_NOM_CODE      17'h04CCC
`define HB_FULL_CODE     17'h07FFF
`define HB_HALF_CODE     18'h04000
`define HB_MA_MUL        16'hD1B6
`define HB_AMP_PWM_MUL   7'h21
`define HB_AMP_CUR_MUL   9'h13B
`define HB_DITH_INC      14'h218E
`define HB_SAT16         16'hFFFF
`define HB_RST16         16'h0000
`define HB_MODE_PWM      2'h0
`define HB_MODE_CUR      2'h1
`define HB_MODE_BOOST    2'h2
`define HB_CFG_LIM_L     6
`define HB_CFG_LIM_R     7
`define HB_CFG_LIM_FALL  8
`define HB_CFG_MEAN_SEL  11
`define HB_CFG_MODE_LO   12
`define HB_CFG_MODE_HI   15
`define HB_CTL_TRIG_FALL 0
`define HB_CTL_ARM_TS    1
`define HB_CTL_CAP       2
`define HB_CTL_WOB_OFF   3
`define HB_CTL_ACK       4
`define HB_CTL_MEAN      5
`define HB_CTL_CNT_CLR   6
`define HB_CTL_RUN       7
`define HB_ST_ARMED_N    4
`define HB_ST_TOGGLE     5
`define HB_ST_STOP       6
`define HB_ST_FAULT      7
`endif

// ---- logic/hbpw_enc.v ----
// hbpw_enc.v: quadrature counter, position capture and trigger timer of one channel
`timescale 1ns/100ps
`include "hbpw_defines.vh"
module hbpw_enc (
	// clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire        us_tick,
	// channel inputs
	input  wire        in_a,
	input  wire        in_b,
	input  wire        in_ref,
	input  wire        in_ref_en,
	// control bits
	input  wire        trig_fall,
	input  wire        arm_timestamp,
	input  wire        cap_start,
	input  wire        cnt_clr,
	// results
	output reg  [15:0] pos_ff,
	output reg  [15:0] cap_ff,
	output reg  [15:0] usec_ff,
	output reg         capture_armed_n,
	output reg         capture_toggle
);
	reg a_ff, b_ff, ref_ff, arm_ff, cap_ff_d, run_ff, wait_ff;
	wire mv      = (in_a ^ a_ff) ^ (in_b ^ b_ff);
	wire up      = in_a ^ b_ff;
	wire ref_rise = in_ref & ~ref_ff;
	wire ref_fall = ~in_ref & ref_ff;
	wire trig_ev = trig_fall ? ref_fall : ref_rise;
	wire cap_ev  = ~capture_armed_n & ref_rise & in_ref_en;
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			a_ff <= 1'b0;
			b_ff <= 1'b0;
			ref_ff <= 1'b0;
			arm_ff <= 1'b0;
			cap_ff_d <= 1'b0;
			run_ff <= 1'b0;
			wait_ff <= 1'b0;
			pos_ff <= `HB_RST16;
			cap_ff <= `HB_RST16;
			usec_ff <= `HB_RST16;
			capture_armed_n <= 1'b1;
			capture_toggle <= 1'b0;
		end else begin
			a_ff <= in_a;
			b_ff <= in_b;
			ref_ff <= in_ref;
			arm_ff <= arm_timestamp;
			cap_ff_d <= cap_start;
			if (cnt_clr) begin
				pos_ff <= `HB_RST16;
				cap_ff <= `HB_RST16;
				capture_armed_n <= 1'b1;
				capture_toggle <= 1'b0;
			end else begin
				// one edge of A or B counts; both at once is dropped
				if (mv) pos_ff <= up ? pos_ff + 16'h0001 : pos_ff - 16'h0001;
				if (cap_ev) begin
					cap_ff <= pos_ff;
					capture_armed_n <= 1'b1;
					capture_toggle <= ~capture_toggle;
				end else if (cap_start & ~cap_ff_d) begin
					capture_armed_n <= 1'b0;
				end
			end
			if (arm_timestamp ^ arm_ff) begin
				usec_ff <= `HB_RST16;
				wait_ff <= 1'b1;
				run_ff <= 1'b0;
			end else if (wait_ff & trig_ev) begin
				wait_ff <= 1'b0;
				run_ff <= 1'b1;
			end else if (run_ff & us_tick & (usec_ff != `HB_SAT16)) begin
				usec_ff <= usec_ff + 16'h0001;
			end
		end
	end
endmodule // hbpw_enc

// ---- logic/hbpw_top.v ----
// hbpw_top.v: four-channel H-bridge controller with PWM, current and boost-and-hold modes
`timescale 1ns/100ps
`include "hbpw_defines.vh"
// How it works
// - inrush setpoint is signed milliamperes, accepted and clamped to 0..10000.
// - inrush duration in microseconds, rounded up to whole 50 us steps.
// - after the inrush time the pulse continues at the hold level, 0..6000 mA.
// - profile period 2000..65535 us, rounded up to whole 50 us steps.
// - profile counters restart on enable, so channels started together stay in phase.
// - dither runs when amplitude and rate are nonzero and wobble_off is clear.
// - boost-and-hold mode never applies dither.
// - amplitude 0..255 scales to 0..25.5 percent of period or nominal current.
// - dither rate counts 2 Hz steps, 0..510 Hz.
// - PWM duty follows setpoint magnitude; the sign picks the driven output.
// - current mode code 19660 is 6 A; above it is allowed only two seconds.
// - boost pulse width is a fraction of profile period, 50 us resolution, live.
// - one chopper period, 20..65535 us, shared by all channels.
// - each channel keeps a signed 16-bit quadrature counter from A and B.
// - a capture event copies the counter into the captured position.
// - timer counts microseconds after trigger and sticks at 65535 until rearmed.
// - with control bit 5 set, config bit 11 shows average current in the timer register instead.
// - status bits 0..3 show the four digital inputs of the channel.
// - status bit 4 is low while a capture is armed, high when idle.
// - status bit 5 flips after every successful capture.
// - status bit 6 marks a reached travel stop and turns the output off.
// - channels 3,4 status are 8 bits; channels 1,2 widen to 16 in model 254.
// - status bit 7 is the OR of open-load and overcurrent flags.
// - toggling arm_timestamp clears the timer; counting starts at next trigger edge.
module hbpw_top #(
	parameter HI_CUR_TICKS = `HB_HI_CUR_TICKS
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	// cyclic registers from the controller, channel n in the n-th slice
	input  wire [63:0] inrush_current_setpoint,
	input  wire [63:0] inrush_duration,
	input  wire [63:0] hold_level_setpoint,
	input  wire [63:0] profile_period,
	input  wire [31:0] wobble_amplitude,
	input  wire [31:0] wobble_rate,
	input  wire [63:0] drive_setpoint,
	input  wire [15:0] chopper_period,
	input  wire [63:0] chan_config,
	input  wire [31:0] chan_control,
	input  wire        func_model_254,
	input  wire [7:0]  global_error,
	// field side
	input  wire [15:0] dig_in,
	input  wire [63:0] meas_current,
	input  wire [3:0]  open_load_evt,
	input  wire [3:0]  over_cur_evt,
	// bridge outputs
	output wire [3:0]  out_pos,
	output wire [3:0]  out_neg,
	// cyclic registers to the controller
	output wire [63:0] encoder_position,
	output wire [63:0] captured_position,
	output wire [63:0] elapsed_micros,
	output wire [31:0] channel_input_status,
	output reg  [15:0] status_wide_1,
	output reg  [15:0] status_wide_2,
	output reg  [7:0]  chan_error
);
	// shared microsecond, 50 us and chopper timebases
	reg [3:0]  us_div_ff;
	reg        us_tick_ff;
	reg [5:0]  st_div_ff;
	reg        st_tick_ff;
	reg [15:0] chop_cnt_ff;
	reg        chop_start_ff;
	wire [15:0] chop_len = (chopper_period < `HB_CHOP_MIN_US) ? `HB_CHOP_MIN_US
		: chopper_period;
	wire [7:0] err_w;
	localparam [15:0] HI_LIM = HI_CUR_TICKS[15:0];
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			us_div_ff <= 4'h0;
			us_tick_ff <= 1'b0;
			st_div_ff <= 6'h00;
			st_tick_ff <= 1'b0;
			chop_cnt_ff <= `HB_RST16;
			chop_start_ff <= 1'b0;
		end else begin
			us_tick_ff <= (us_div_ff == `HB_US_LAST);
			us_div_ff <= (us_div_ff == `HB_US_LAST) ? 4'h0 : us_div_ff + 4'h1;
			st_tick_ff <= us_tick_ff & (st_div_ff == `HB_ST_LAST);
			chop_start_ff <= us_tick_ff & (chop_cnt_ff >= chop_len - 16'h0001);
			if (us_tick_ff) begin
				st_div_ff <= (st_div_ff == `HB_ST_LAST) ? 6'h00 : st_div_ff + 6'h01;
				chop_cnt_ff <= (chop_cnt_ff >= chop_len - 16'h0001) ? `HB_RST16
					: chop_cnt_ff + 16'h0001;
			end
		end
	end
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : ch
			wire [15:0] sp    = drive_setpoint[16*g +: 16];
			wire [15:0] cfg   = chan_config[16*g +: 16];
			wire [7:0]  ctl   = chan_control[8*g +: 8];
			wire [7:0]  amp   = wobble_amplitude[8*g +: 8];
			wire [7:0]  rate  = wobble_rate[8*g +: 8];
			wire [15:0] meas  = meas_current[16*g +: 16];
			wire [3:0]  din   = dig_in[4*g +: 4];
			wire [1:0]  mode  = {cfg[`HB_CFG_MODE_HI], cfg[`HB_CFG_MODE_LO]};
			wire        neg   = sp[15];
			reg         ack_ff, run_ff, l_ff, r_ff;
			reg         ol_ff, oc_ff, stop_ff, cur_on_ff;
			reg         out_pos_ff, out_neg_ff;
			reg  [31:0] phase_ff;
			reg  [15:0] hi_cnt_ff, avg_ff, cap_out_ff, usec_out_ff;
			reg  [10:0] prof_cnt_ff, on_cnt_ff;
			reg  [7:0]  stat_ff;
			wire [15:0] pos_w, cap_w, usec_w;
			wire        armed_n_w, tog_w;
			wire ack_rise = ctl[`HB_CTL_ACK] & ~ack_ff;
			wire run_rise = ctl[`HB_CTL_RUN] & ~run_ff;
			wire err_clr  = ack_rise | run_rise;
			// travel stop: selected edge on left or right limit input
			wire l_ev = cfg[`HB_CFG_LIM_FALL] ? (~din[2] & l_ff) : (din[2] & ~l_ff);
			wire r_ev = cfg[`HB_CFG_LIM_FALL] ? (~din[3] & r_ff) : (din[3] & ~r_ff);
			wire stop_set = (cfg[`HB_CFG_LIM_L] & l_ev) | (cfg[`HB_CFG_LIM_R] & r_ev);
			wire stop_off = ack_rise | ~(cfg[`HB_CFG_LIM_L] | cfg[`HB_CFG_LIM_R]);
			// setpoint magnitude, 0..32768
			wire [16:0] mag = neg ? (~{1'b1, sp} + 17'h00001) : {1'b0, sp};
			// dither: triangle from a phase accumulator stepped each microsecond
			wire [21:0] dinc  = rate * `HB_DITH_INC;
			wire [14:0] tri_w = phase_ff[31] ? ~phase_ff[30:16] : phase_ff[30:16];
			wire signed [17:0] tri_c = $signed({3'b000, tri_w}) - $signed(`HB_HALF_CODE);
			wire [16:0] amp_cur = amp * `HB_AMP_CUR_MUL;
			wire [14:0] amp_pwm = amp * `HB_AMP_PWM_MUL;
			wire [14:0] amp_sc = (mode == `HB_MODE_PWM) ? amp_pwm
				: {2'b00, amp_cur[16:4]};
			wire signed [33:0] dprod = tri_c * $signed({1'b0, amp_sc});
			wire wob_on = (amp != 8'h00) & (rate != 8'h00) & ~ctl[`HB_CTL_WOB_OFF]
				& (mode != `HB_MODE_BOOST);
			wire signed [18:0] eff_s = $signed({2'b00, mag})
				+ (wob_on ? $signed(dprod[31:14]) : 19'sh00000);
			wire [16:0] eff_c = eff_s[18] ? 17'h00000
				: (eff_s > $signed({2'b00, `HB_FULL_CODE})) ? `HB_FULL_CODE : eff_s[16:0];
			wire hi_lim = (mode == `HB_MODE_CUR) & (hi_cnt_ff >= HI_LIM);
			wire [16:0] eff = (hi_lim & (eff_c > `HB_NOM_CODE)) ? `HB_NOM_CODE : eff_c;
			// PWM: on while chopper count is below the duty share of the period
			wire [32:0] on_prod = eff * chop_len;
			wire pwm_on = (eff == `HB_FULL_CODE) | (chop_cnt_ff < on_prod[30:15]);
			// boost-and-hold profile in 50 us steps
			wire [16:0] pp_r = {1'b0, profile_period[16*g +: 16]} + `HB_STEP_ROUND;
			wire [16:0] pp_d = pp_r / `HB_STEP_DIV;
			wire [10:0] prof_tk = (pp_d[10:0] < `HB_PROF_MIN_TK) ? `HB_PROF_MIN_TK
				: pp_d[10:0];
			wire [16:0] bd_r = {1'b0, inrush_duration[16*g +: 16]} + `HB_STEP_ROUND;
			wire [16:0] bd_d = bd_r / `HB_STEP_DIV;
			wire [27:0] pw_prod = mag * prof_tk;
			wire pulse_on = ctl[`HB_CTL_RUN] & ((mag >= `HB_FULL_CODE)
				| ({1'b0, prof_cnt_ff} < pw_prod[26:15]));
			wire in_boost = on_cnt_ff < bd_d[10:0];
			// milliamperes to 10 A / 32767 codes, range clamped
			wire [15:0] ir_raw = inrush_current_setpoint[16*g +: 16];
			wire [15:0] ho_raw = hold_level_setpoint[16*g +: 16];
			wire [15:0] ir_ma = ir_raw[15] ? `HB_RST16
				: (ir_raw > `HB_INRUSH_MAX_MA) ? `HB_INRUSH_MAX_MA : ir_raw;
			wire [15:0] ho_ma = ho_raw[15] ? `HB_RST16
				: (ho_raw > `HB_HOLD_MAX_MA) ? `HB_HOLD_MAX_MA : ho_raw;
			wire [31:0] ir_code = ir_ma * `HB_MA_MUL;
			wire [31:0] ho_code = ho_ma * `HB_MA_MUL;
			wire [16:0] b_tgt = {1'b0, in_boost ? ir_code[29:14] : ho_code[29:14]};
			wire [16:0] tgt = (mode == `HB_MODE_BOOST) ? b_tgt : eff;
			wire [16:0] mmag = meas[15] ? (~{1'b1, meas} + 17'h00001) : {1'b0, meas};
			wire signed [16:0] avg_d = $signed({meas[15], meas}) - $signed({avg_ff[15], avg_ff});
			wire signed [16:0] avg_s = avg_d >>> 4;
			reg  on_w;
			always @* begin
				case (mode)
					`HB_MODE_PWM: on_w = pwm_on;
					`HB_MODE_CUR: on_w = cur_on_ff;
					`HB_MODE_BOOST: on_w = pulse_on & cur_on_ff;
					default: on_w = 1'b0;
				endcase
			end
			wire drive = on_w & ~stop_ff & ~oc_ff;
			always @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					ack_ff <= 1'b0;
					run_ff <= 1'b0;
					l_ff <= 1'b0;
					r_ff <= 1'b0;
					ol_ff <= 1'b0;
					oc_ff <= 1'b0;
					stop_ff <= 1'b0;
					cur_on_ff <= 1'b0;
					out_pos_ff <= 1'b0;
					out_neg_ff <= 1'b0;
					phase_ff <= 32'h00000000;
					hi_cnt_ff <= `HB_RST16;
					avg_ff <= `HB_RST16;
					cap_out_ff <= `HB_RST16;
					usec_out_ff <= `HB_RST16;
					prof_cnt_ff <= 11'h000;
					on_cnt_ff <= 11'h000;
					stat_ff <= 8'h10;
				end else begin
					ack_ff <= ctl[`HB_CTL_ACK];
					run_ff <= ctl[`HB_CTL_RUN];
					l_ff <= din[2];
					r_ff <= din[3];
					// a new fault in the clearing cycle is kept
					ol_ff <= open_load_evt[g] | (ol_ff & ~err_clr);
					oc_ff <= over_cur_evt[g] | (oc_ff & ~err_clr);
					stop_ff <= stop_set | (stop_ff & ~stop_off);
					if (us_tick_ff) begin
						phase_ff <= phase_ff + {10'h000, dinc};
						avg_ff <= avg_ff + avg_s[15:0];
					end
					// current chopper: switch on at period start, off at target
					if (chop_start_ff) cur_on_ff <= (mmag < tgt);
					else if (mmag >= tgt) cur_on_ff <= 1'b0;
					if (mode != `HB_MODE_CUR || eff_c <= `HB_NOM_CODE) hi_cnt_ff <= `HB_RST16;
					else if (st_tick_ff && hi_cnt_ff < HI_LIM)
						hi_cnt_ff <= hi_cnt_ff + 16'h0001;
					if (run_rise | ~ctl[`HB_CTL_RUN]) prof_cnt_ff <= 11'h000;
					else if (st_tick_ff) prof_cnt_ff <= (prof_cnt_ff >= prof_tk - 11'h001)
						? 11'h000 : prof_cnt_ff + 11'h001;
					// inrush needs a 50 us gap; a continuous pulse stays on hold
					if (st_tick_ff) begin
						if (!pulse_on) on_cnt_ff <= 11'h000;
						else if (on_cnt_ff != 11'h7FF) on_cnt_ff <= on_cnt_ff + 11'h001;
					end
					out_pos_ff <= drive & ~neg;
					out_neg_ff <= drive & neg;
					cap_out_ff <= (ctl[`HB_CTL_MEAN] & ~cfg[`HB_CFG_MEAN_SEL]) ? avg_ff : cap_w;
					usec_out_ff <= (ctl[`HB_CTL_MEAN] & cfg[`HB_CFG_MEAN_SEL])
						? avg_ff : usec_w;
					stat_ff <= {ol_ff | oc_ff, stop_ff, tog_w, armed_n_w, din};
				end
			end
			hbpw_enc u_enc (
				.clk_sys         (clk_sys),
				.sys_rst         (sys_rst),
				.us_tick         (us_tick_ff),
				.in_a            (din[0]),
				.in_b            (din[1]),
				.in_ref          (din[2]),
				.in_ref_en       (din[3]),
				.trig_fall       (ctl[`HB_CTL_TRIG_FALL]),
				.arm_timestamp   (ctl[`HB_CTL_ARM_TS]),
				.cap_start       (ctl[`HB_CTL_CAP]),
				.cnt_clr         (ctl[`HB_CTL_CNT_CLR]),
				.pos_ff          (pos_w),
				.cap_ff          (cap_w),
				.usec_ff         (usec_w),
				.capture_armed_n (armed_n_w),
				.capture_toggle  (tog_w)
			);
			assign out_pos[g] = out_pos_ff;
			assign out_neg[g] = out_neg_ff;
			assign encoder_position[16*g +: 16] = pos_w;
			assign captured_position[16*g +: 16] = cap_out_ff;
			assign elapsed_micros[16*g +: 16] = usec_out_ff;
			assign channel_input_status[8*g +: 8] = stat_ff;
			assign err_w[2*g] = ol_ff;
			assign err_w[2*g+1] = oc_ff;
		end
	endgenerate
	// wide status of channels 1 and 2 exists only in model 254
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			status_wide_1 <= `HB_RST16;
			status_wide_2 <= `HB_RST16;
			chan_error <= 8'h00;
		end else begin
			chan_error <= err_w;
			status_wide_1 <= func_model_254 ? {global_error[7:4], 4'h0,
				channel_input_status[7:0]} : `HB_RST16;
			status_wide_2 <= func_model_254 ? {err_w, channel_input_status[15:8]}
				: `HB_RST16;
		end
	end
endmodule // hbpw_top

// ---- tb/hbpw_chk.sv ----
// hbpw_chk.sv: port assertions of the bridge controller, watched on channel 0
`timescale 1ns/100ps
module hbpw_chk (
	// clock and reset
	input wire        clk_sys,
	input wire        sys_rst,
	// stimulus seen at the ports
	input wire [15:0] dig_in,
	input wire [63:0] chan_config,
	input wire [31:0] chan_control,
	input wire [63:0] drive_setpoint,
	input wire [31:0] wobble_amplitude,
	input wire        func_model_254,
	input wire [3:0]  over_cur_evt,
	// results
	input wire [3:0]  out_pos,
	input wire [3:0]  out_neg,
	input wire [63:0] encoder_position,
	input wire [63:0] captured_position,
	input wire [63:0] elapsed_micros,
	input wire [31:0] channel_input_status,
	input wire [15:0] status_wide_1,
	input wire [15:0] status_wide_2
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire quiet0 = !chan_config[15] && !chan_config[12] && wobble_amplitude[7:0] == 8'h00
		&& channel_input_status[7:6] == 2'b00;
	sequence s_step_up;
		$rose(dig_in[0]) && $stable(dig_in[1]) && !dig_in[1] && !chan_control[6];
	endsequence
	sequence s_armed;
		$rose(chan_control[2]) ##0 (!chan_control[6] && $stable(dig_in[3:2]))[*4];
	endsequence
	sequence s_full;
		(quiet0 && !over_cur_evt[0] && $stable(dig_in[3:2])
			&& drive_setpoint[15:0] == 16'h7FFF)[*3];
	endsequence
	inputs_mirror_a: assert property ($stable(dig_in[3:0])[*3] |->
		channel_input_status[3:0] == dig_in[3:0]) else $error("status inputs wrong");
	wide_idle_a: assert property (!func_model_254 |=>
		status_wide_1 == 16'h0000 && status_wide_2 == 16'h0000) else $error("wide status set");
	count_up_a: assert property (s_step_up |=>
		encoder_position[15:0] == $past(encoder_position[15:0]) + 16'h0001)
		else $error("count step wrong");
	count_clear_a: assert property ((chan_control[6] && !chan_control[5])[*3] |->
		encoder_position[15:0] == 16'h0000 && captured_position[15:0] == 16'h0000
		&& channel_input_status[5:4] == 2'b01) else $error("clear incomplete");
	capture_arm_a: assert property (s_armed |-> !channel_input_status[4])
		else $error("capture not armed");
	toggle_idle_a: assert property ($changed(channel_input_status[5]) |->
		channel_input_status[4]) else $error("toggle while armed");
	timer_mono_a: assert property ((!chan_control[5] && $stable(chan_control[1]))[*4] |->
		elapsed_micros[15:0] >= $past(elapsed_micros[15:0])) else $error("timer fell");
	timer_clear_a: assert property ($changed(chan_control[1]) && !chan_control[5] |->
		##[1:3] elapsed_micros[15:0] == 16'h0000) else $error("timer not cleared");
	zero_off_a: assert property ((quiet0 && drive_setpoint[15:0] == 16'h0000)[*3] |->
		!out_pos[0] && !out_neg[0]) else $error("zero setpoint drives");
	full_on_a: assert property (s_full |-> out_pos[0] && !out_neg[0])
		else $error("full setpoint not high");
	stop_off_a: assert property (
		(channel_input_status[6] && !chan_control[4] && chan_config[7:6] != 2'b00)[*3]
		|-> !out_pos[0] && !out_neg[0]) else $error("output on at stop");
endmodule // hbpw_chk

// ---- tb/hbpw_ctrl_model.sv ----
// hbpw_ctrl_model.sv: cyclic controller handing one whole register image per transfer
`timescale 1ns/100ps
module hbpw_ctrl_model (
	// clock
	input  wire         clk_sys,
	// image prepared by the bench
	input  wire  [31:0] img_control,
	input  wire  [63:0] img_config,
	input  wire  [63:0] img_setpoint,
	// image seen by the device
	output logic [31:0] chan_control,
	output logic [63:0] chan_config,
	output logic [63:0] drive_setpoint
);
	// all channels change in the same transfer, arm bit only ever toggled
	always @(posedge clk_sys) begin
		chan_control   <= img_control;
		chan_config    <= img_config;
		drive_setpoint <= img_setpoint;
	end
endmodule // hbpw_ctrl_model

// ---- tb/hbpw_top_bench.sv ----
// hbpw_top_bench.sv: self-checking bench of the four-channel bridge controller
`timescale 1ns/100ps
module hbpw_top_bench;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [15:0] dig_in = 16'h0000;
	logic [31:0] ctl = 32'h0000_0000;
	logic [63:0] cfg = 64'h0;
	logic [63:0] sp = 64'h0;
	logic [63:0] inrush_ma = {4{16'h03E8}};
	logic [63:0] inrush_us = {4{16'h0064}};
	logic [63:0] hold_ma = {4{16'h01F4}};
	logic [63:0] prof_us = {4{16'h07D0}};
	logic [63:0] meas = 64'h0;
	logic [31:0] wob = 32'h0000_0000;
	logic [15:0] chop = 16'h0014;
	logic [7:0]  gerr = 8'h00;
	logic [3:0]  ol_evt = 4'h0;
	logic [3:0]  oc_evt = 4'h0;
	logic        fm254 = 1'b0;
	wire  [3:0]  o_pos, o_neg;
	wire  [63:0] enc, capp, usec, m_cfg, m_sp;
	wire  [31:0] stat, m_ctl;
	wire  [15:0] sw1, sw2;
	wire  [7:0]  cerr;
	int          bad_count = 0;
	int          compares = 0;
	int          hi;
	always #50 clk_sys = ~clk_sys;
	hbpw_ctrl_model u_ctrl (.clk_sys(clk_sys), .img_control(ctl), .img_config(cfg),
		.img_setpoint(sp), .chan_control(m_ctl), .chan_config(m_cfg), .drive_setpoint(m_sp));
	hbpw_top #(.HI_CUR_TICKS(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.inrush_current_setpoint(inrush_ma), .inrush_duration(inrush_us),
		.hold_level_setpoint(hold_ma), .profile_period(prof_us), .wobble_amplitude(wob),
		.wobble_rate(wob), .drive_setpoint(m_sp), .chopper_period(chop), .chan_config(m_cfg),
		.chan_control(m_ctl), .func_model_254(fm254), .global_error(gerr), .dig_in(dig_in),
		.meas_current(meas), .open_load_evt(ol_evt), .over_cur_evt(oc_evt), .out_pos(o_pos),
		.out_neg(o_neg), .encoder_position(enc), .captured_position(capp),
		.elapsed_micros(usec), .channel_input_status(stat), .status_wide_1(sw1),
		.status_wide_2(sw2), .chan_error(cerr));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#10;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// n quadrature steps, forward or back
	task automatic quad(input int n, input bit up);
		repeat (n) begin
			if ((dig_in[0] == dig_in[1]) == up)
				dig_in[0] = ~dig_in[0];
			else
				dig_in[1] = ~dig_in[1];
			cyc(2);
		end
	endtask
	task automatic t_reset;
		chk("status", 32'h1010_1010, stat);
		chk("wide1", 16'h0000, sw1);
		chk("drive", 8'h00, {o_pos, o_neg});
	endtask
	task automatic t_inputs;
		for (int i = 0; i < 16; i++) begin
			dig_in = 16'h0001 << i;
			cyc(3);
			chk("status", 32'h1010_1010 | (32'h1 << (i / 4 * 8 + i % 4)), stat);
		end
		dig_in = 16'h0000;
		cyc(2);
	endtask
	task automatic t_encoder;
		ctl[6] = 1'b1;
		cyc(4);
		chk("position", 16'h0000, enc[15:0]);
		ctl[6] = 1'b0;
		cyc(2);
		quad(5, 1'b1);
		chk("position", 16'h0005, enc[15:0]);
		quad(7, 1'b0);
		chk("position", 16'hFFFE, enc[15:0]);
	endtask
	task automatic t_capture;
		ctl[2] = 1'b1;
		cyc(4);
		chk("armed_n", 1'b0, stat[4]);
		dig_in[3] = 1'b1;
		cyc(2);
		dig_in[2] = 1'b1;
		cyc(4);
		chk("captured", 16'hFFFE, capp[15:0]);
		chk("cap bits", 2'b11, stat[5:4]);
		ctl[2] = 1'b0;
		dig_in[3:2] = 2'b00;
		cyc(2);
	endtask
	task automatic t_timer;
		ctl[1] = ~ctl[1];
		cyc(24);
		chk("timer idle", 16'h0000, usec[15:0]);
		dig_in[2] = 1'b1;
		cyc(500);
		chk("timer 50us", 1'b1, usec[15:0] >= 16'h0030 && usec[15:0] <= 16'h0033);
		dig_in[2] = 1'b0;
	endtask
	task automatic t_pwm;
		sp[15:0] = 16'h7FFF;
		cyc(4);
		chk("drive full", 2'b10, {o_pos[0], o_neg[0]});
		sp[15:0] = 16'h8001;
		cyc(4);
		chk("drive neg", 2'b01, {o_pos[0], o_neg[0]});
		sp[15:0] = 16'h4000;
		cyc(4);
		hi = 0;
		for (int i = 0; i < 400; i++) begin
			hi += o_pos[0];
			cyc(1);
		end
		chk("half duty", 1'b1, hi >= 196 && hi <= 204);
	endtask
	task automatic t_stop;
		cfg[6] = 1'b1;
		sp[15:0] = 16'h7FFF;
		cyc(4);
		dig_in[2] = 1'b1;
		cyc(4);
		chk("stop", 3'b100, {stat[6], o_pos[0], o_neg[0]});
		ctl[4] = 1'b1;
		cyc(4);
		ctl[4] = 1'b0;
		cyc(4);
		chk("stop ack", 3'b010, {stat[6], o_pos[0], o_neg[0]});
		dig_in[2] = 1'b0;
	endtask
	task automatic t_fault;
		fm254 = 1'b1;
		oc_evt[0] = 1'b1;
		cyc(1);
		oc_evt[0] = 1'b0;
		cyc(4);
		chk("fault", 4'b1100, {stat[7], cerr[1], o_pos[0], o_neg[0]});
		chk("wide2 oc", 1'b1, sw2[9]);
		ctl[4] = 1'b1;
		cyc(4);
		chk("fault ack", 3'b001, {stat[7], cerr[1], o_pos[0]});
		ctl[4] = 1'b0;
	endtask
	task automatic t_current;
		cfg[12] = 1'b1;
		sp[15:0] = 16'h7000;
		meas[15:0] = 16'h5000;
		cyc(250);
		chk("current on", 1'b1, o_pos[0]);
		cyc(2500);
		chk("current limit", 1'b0, o_pos[0]);
		ctl[5] = 1'b1;
		cfg[11] = 1'b1;
		cyc(4);
		chk("mean current", 1'b1, usec[15:0] >= 16'h4FF0 && usec[15:0] <= 16'h5000);
		ctl[5] = 1'b0;
		cfg[11] = 1'b0;
	endtask
	// count cycles with the positive output of channel 0 driven
	task automatic count_hi(input int n);
		hi = 0;
		repeat (n) begin
			hi += o_pos[0];
			cyc(1);
		end
	endtask
	task automatic t_boost;
		cfg[15:12] = 4'h8;
		sp[15:0] = 16'h4000;
		meas[15:0] = 16'h0000;
		ctl[7] = 1'b1;
		cyc(2);
		count_hi(15000);
		chk("boost width", 1'b1, hi >= 9300 && hi <= 10010);
		ctl[7] = 1'b0;
		meas[15:0] = 16'h0900;
		cyc(600);
		ctl[7] = 1'b1;
		cyc(2);
		count_hi(3000);
		chk("inrush only", 1'b1, hi >= 450 && hi <= 1010);
		ctl[7] = 1'b0;
	endtask
	initial begin
		cyc(6);
		sys_rst = 1'b0;
		cyc(2);
		t_reset();
		t_inputs();
		t_encoder();
		t_capture();
		t_timer();
		t_pwm();
		t_stop();
		t_fault();
		t_current();
		t_boost();
		wrap_up();
	end
endmodule // hbpw_top_bench
bind hbpw_top hbpw_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .dig_in(dig_in),
	.chan_config(chan_config), .chan_control(chan_control), .drive_setpoint(drive_setpoint),
	.wobble_amplitude(wobble_amplitude), .func_model_254(func_model_254),
	.over_cur_evt(over_cur_evt), .out_pos(out_pos), .out_neg(out_neg),
	.encoder_position(encoder_position), .captured_position(captured_position),
	.elapsed_micros(elapsed_micros), .channel_input_status(channel_input_status),
	.status_wide_1(status_wide_1), .status_wide_2(status_wide_2));
